// [hdl/fsq_defs.svh]
/*
  Constants of the flash sequencer: address map, lock byte places, control bit positions,
  timing figures and the offsets of the controller's own registers.
  Assumes it is included by its bare name wherever a constant is needed.
*/
`ifndef FSQ_DEFS_SVH
`define FSQ_DEFS_SVH

// ----------------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------------
`define FSQ_AW              16
`define FSQ_FLASH_BYTES     65536
`define FSQ_SCR_BYTES       128
`define FSQ_SCR_AW          7
`define FSQ_SCR_LIMIT       16'h0080
`define FSQ_EXTERNAL_DATA_RAM_BYTES      4096
`define FSQ_EXTERNAL_DATA_RAM_AW         12
`define FSQ_PAGE_AW         9
`define FSQ_PAGE_LAST       9'h1ff
`define FSQ_SCR_LAST        9'h07f
`define FSQ_RESERVED_BASE   16'hfe00
`define FSQ_LOCK_READ_ADDR  16'hfdff
`define FSQ_LOCK_WRITE_ADDR 16'hfdfe
`define FSQ_LOCK_PAGE       7'h7e
`define FSQ_BLOCK_LSB       13
`define FSQ_TOP_BLOCK       7
`define FSQ_RESET_VECTOR    16'h0000
`define FSQ_ERASED          8'hff
`define FSQ_UNDEF_DATA      8'h00

// ----------------------------------------------------------------------------
// Control bits
// ----------------------------------------------------------------------------
`define FSQ_PROGRAM_STORE_CONTROL_REDIRECT  0
`define FSQ_PROGRAM_STORE_CONTROL_ERASE     1
`define FSQ_PROGRAM_STORE_CONTROL_SCRATCH   2
`define FSQ_FLASH_MEMORY_CONTROL_ALLOW     0
`define FSQ_SEL_PROGRAM_STORE_CONTROL       1'b0
`define FSQ_SEL_FLASH_MEMORY_CONTROL       1'b1

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FSQ_CLK_PERIOD_NS   5
`define FSQ_WRITE_TIME_US   50
`define FSQ_ERASE_TIME_MS   12
`define FSQ_TMR_W           22

// ----------------------------------------------------------------------------
// Controller registers
// ----------------------------------------------------------------------------
`define FSQ_R_ADDR_LO       4'h0
`define FSQ_R_ADDR_HI       4'h1
`define FSQ_R_DATA          4'h2
`define FSQ_R_CMD           4'h3
`define FSQ_R_STATUS        4'h4
`define FSQ_R_RESULT        4'h5
`define FSQ_R_IRQ_PEND      4'h6

`endif

// [hdl/fsq_pkg.sv]
/*
  Types shared by both ends of the flash sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fsq_pkg;

  typedef enum logic [2:0]
  {
    fsq_dev_idle  = 3'b001,
    fsq_dev_write = 3'b010,
    fsq_dev_erase = 3'b100
  } fsq_dev_state_t;

  typedef enum logic [2:0]
  {
    fsq_host_idle  = 3'b001,
    fsq_host_issue = 3'b010,
    fsq_host_wait  = 3'b100
  } fsq_host_state_t;

  typedef enum logic [2:0]
  {
    fsq_op_movx_wr  = 3'h0,
    fsq_op_movx_rd  = 3'h1,
    fsq_op_movc_rd  = 3'h2,
    fsq_op_fetch    = 3'h3,
    fsq_op_jtag_rd  = 3'h4,
    fsq_op_jtag_wr  = 3'h5,
    fsq_op_jtag_era = 3'h6,
    fsq_op_sfr_wr   = 3'h7
  } fsq_op_t;

endpackage

// [hdl/fsq_link_if.sv]
/*
  Link between the core/debug side (host) and the flash device.
  Assumes both ends run on the same sys_clk; strobes are one cycle long.
*/
`include "fsq_defs.svh"

interface fsq_link_if;
  logic                movx_wr;
  logic                movx_rd;
  logic                movc_rd;
  logic                movc_fetch;
  logic                jtag_rd;
  logic                jtag_wr;
  logic                jtag_erase;
  logic                sfr_wr;
  logic                sfr_sel;
  logic [`FSQ_AW-1:0]  addr;
  logic [7:0]          wdata;
  logic [7:0]          rdata;
  logic                stall;
  logic                irq_hold;
  logic [3:0]          ctrl_status;

  modport dev
  (
    input  movx_wr, movx_rd, movc_rd, movc_fetch, jtag_rd, jtag_wr, jtag_erase,
    input  sfr_wr, sfr_sel, addr, wdata,
    output rdata, stall, irq_hold, ctrl_status
  );

  modport host
  (
    output movx_wr, movx_rd, movc_rd, movc_fetch, jtag_rd, jtag_wr, jtag_erase,
    output sfr_wr, sfr_sel, addr, wdata,
    input  rdata, stall, irq_hold, ctrl_status
  );
endinterface

// [hdl/fsq_op_timer.sv]
/*
  Down counter that times one flash write or erase.
  Assumes load is a one-cycle pulse and load_value is at least one.
*/
`include "fsq_defs.svh"

module fsq_op_timer
(
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  load,
  input  wire logic [`FSQ_TMR_W-1:0] load_value,
  output logic                       done
);
  logic [`FSQ_TMR_W-1:0] count;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      count <= '0;
    else if (load)
      count <= load_value;
    else if (count != '0)
      count <= count - `FSQ_TMR_W'(1);
  end

  assign done = (count == `FSQ_TMR_W'(1));
endmodule

// [hdl/fsq_device.sv]
/*
  Flash device end: main flash, scratchpad sector, external data RAM, control bits,
  self-timed byte write and page erase, lock byte checks for debug-port access.
  Assumes the host issues one request at a time and none while stall is high.
*/
// Notes on behaviour
// - Byte write only clears bits: old AND new.
// - Erase sets whole 512-byte page to 0xFF.
// - Core stalled through every write or erase.
// - Interrupts held during operation, served afterwards.
// - Hardware times writes and erases itself.
// - Redirect bit steers data writes to flash.
// - Redirect bit cleared only by software.
// - Data reads always come from data RAM.
// - Software modification needs the allow bit.
// - Erase enable plus redirect erases page.
// - Software clears erase, writes, clears redirect.
// - Software masks interrupts while redirect set.
// - Software avoids the reserved top region.
// - Scratchpad select maps 0x00-0x7F to scratchpad.
// - No instruction fetch from the scratchpad.
// - Lock bytes sit at 0xFDFF and 0xFDFE.
// - Read lock bit zero blocks debug reads.
// - Write lock bit zero blocks debug modification.
// - Software may write, never erase, lock page.
// - Locked debug read returns undefined data.
// - Top block locked: lock bytes writable, unerasable.
// - Blank device programmable only via debug port.
`include "fsq_defs.svh"

module fsq_device
  import fsq_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `FSQ_WRITE_TIME_US * 1000 / `FSQ_CLK_PERIOD_NS,
  parameter int unsigned ERASE_CYCLES = `FSQ_ERASE_TIME_MS * 1000000 / `FSQ_CLK_PERIOD_NS
)
(
  input  wire logic sys_clk,
  input  wire logic reset,
  fsq_link_if.dev   link,
  output logic      op_busy,
  output logic      op_refused
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  // Unprogrammed flash holds the erased value; data RAM starts cleared. Reset leaves them alone.
  logic [7:0] flash_mem   [0:`FSQ_FLASH_BYTES-1] = '{default: `FSQ_ERASED};
  logic [7:0] scratch_mem [0:`FSQ_SCR_BYTES-1]   = '{default: `FSQ_ERASED};
  logic [7:0] external_data_ram_mem    [0:`FSQ_EXTERNAL_DATA_RAM_BYTES-1]  = '{default: 8'h00};

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic block_open(input logic [7:0] lock, input logic [`FSQ_AW-1:0] a);
    block_open = lock[a[`FSQ_AW-1:`FSQ_BLOCK_LSB]];
  endfunction

  function automatic logic is_lock_byte(input logic [`FSQ_AW-1:0] a);
    is_lock_byte = (a == `FSQ_LOCK_READ_ADDR) || (a == `FSQ_LOCK_WRITE_ADDR);
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  fsq_dev_state_t          state;
  fsq_dev_state_t          next_state;
  logic                    redirect;
  logic                    erase_en;
  logic                    scratch_sel;
  logic                    sw_allow;
  logic [`FSQ_AW-1:0]      op_addr;
  logic                    op_scratch;
  logic [`FSQ_PAGE_AW-1:0] sweep_idx;
  logic                    sweep_done;
  logic                    tmr_load;
  logic [`FSQ_TMR_W-1:0]   tmr_value;
  logic                    tmr_done;

  // --------------------------------------------------------------------------
  // Request decode
  // --------------------------------------------------------------------------
  wire        idle        = (state == fsq_dev_idle);
  wire [7:0]  lock_rd     = flash_mem[`FSQ_LOCK_READ_ADDR];
  wire [7:0]  lock_we     = flash_mem[`FSQ_LOCK_WRITE_ADDR];
  wire        reserved    = (link.addr >= `FSQ_RESERVED_BASE);
  wire        lock_page   = (link.addr[`FSQ_AW-1:`FSQ_PAGE_AW] == `FSQ_LOCK_PAGE);
  wire        to_scratch  = scratch_sel && (link.addr < `FSQ_SCR_LIMIT);
  wire        initialised = (flash_mem[`FSQ_RESET_VECTOR] != `FSQ_ERASED);
  wire        sw_mod      = link.movx_wr && redirect;
  wire        sw_ok       = sw_allow && initialised && (to_scratch || !reserved);
  wire        sw_write_ok = sw_mod && !erase_en && sw_ok;
  wire        sw_erase_ok = sw_mod && erase_en && sw_ok && (to_scratch || !lock_page);
  // Lock bytes take writes even when their own block is locked.
  wire        jtag_wr_ok  = link.jtag_wr && !reserved &&
                            (block_open(lock_we, link.addr) || is_lock_byte(link.addr));
  // The lock page lies in the top block, so its erase needs that block open.
  wire        jtag_era_ok = link.jtag_erase && !reserved &&
                            block_open(lock_we, link.addr);
  wire        start_write = idle && (sw_write_ok || jtag_wr_ok);
  wire        start_erase = idle && (sw_erase_ok || jtag_era_ok);
  wire        any_mod     = sw_mod || link.jtag_wr || link.jtag_erase;
  wire        wr_scratch  = sw_mod && to_scratch;
  wire        jtag_visible = is_lock_byte(link.addr) || block_open(lock_rd, link.addr);
  wire [`FSQ_AW-1:0] page_base =
    {link.addr[`FSQ_AW-1:`FSQ_PAGE_AW], {`FSQ_PAGE_AW{1'b0}}};

  assign sweep_done = op_scratch ? (sweep_idx == `FSQ_SCR_LAST) : (sweep_idx == `FSQ_PAGE_LAST);
  assign tmr_load   = start_write || start_erase;
  assign tmr_value  = start_erase ? `FSQ_TMR_W'(ERASE_CYCLES) : `FSQ_TMR_W'(WRITE_CYCLES);

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      fsq_dev_idle:
      begin
        if (start_erase)
          next_state = fsq_dev_erase;
        else if (start_write)
          next_state = fsq_dev_write;
      end
      fsq_dev_write:
      begin
        if (tmr_done)
          next_state = fsq_dev_idle;
      end
      fsq_dev_erase:
      begin
        // The timer ends the erase even if the sweep has not finished the page; the sweep alone ends it only when tmr_value is zero.
        if (tmr_done || (sweep_done && tmr_value == '0))
          next_state = fsq_dev_idle;
      end
      default:
        next_state = fsq_dev_idle;
    endcase
  end

  fsq_op_timer u_timer
  (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .load       (tmr_load),
    .load_value (tmr_value),
    .done       (tmr_done)
  );

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state      <= fsq_dev_idle;
      op_addr    <= '0;
      op_scratch <= 1'b0;
      sweep_idx  <= '0;
      op_refused <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      op_refused <= any_mod && !(start_write || start_erase);
      if (start_erase)
      begin
        op_addr    <= page_base;
        op_scratch <= wr_scratch;
        sweep_idx  <= '0;
      end
      else if (state == fsq_dev_erase && !sweep_done)
        sweep_idx <= sweep_idx + `FSQ_PAGE_AW'(1);
    end
  end

  // --------------------------------------------------------------------------
  // Control bits
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      redirect    <= 1'b0;
      erase_en    <= 1'b0;
      scratch_sel <= 1'b0;
      sw_allow    <= 1'b0;
    end
    else if (link.sfr_wr && idle)
    begin
      // Only software writes touch these; no operation ever clears them.
      if (link.sfr_sel == `FSQ_SEL_PROGRAM_STORE_CONTROL)
      begin
        redirect    <= link.wdata[`FSQ_PROGRAM_STORE_CONTROL_REDIRECT];
        erase_en    <= link.wdata[`FSQ_PROGRAM_STORE_CONTROL_ERASE];
        scratch_sel <= link.wdata[`FSQ_PROGRAM_STORE_CONTROL_SCRATCH];
      end
      else
        sw_allow <= link.wdata[`FSQ_FLASH_MEMORY_CONTROL_ALLOW];
    end
  end

  // --------------------------------------------------------------------------
  // Memory updates and reads
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (start_write)
    begin
      if (wr_scratch)
        scratch_mem[link.addr[`FSQ_SCR_AW-1:0]] <=
          scratch_mem[link.addr[`FSQ_SCR_AW-1:0]] & link.wdata;
      else
        flash_mem[link.addr] <= flash_mem[link.addr] & link.wdata;
    end
    if (state == fsq_dev_erase)
    begin
      if (op_scratch)
        scratch_mem[sweep_idx[`FSQ_SCR_AW-1:0]] <= `FSQ_ERASED;
      else
        flash_mem[op_addr | `FSQ_AW'(sweep_idx)] <= `FSQ_ERASED;
    end
    if (link.movx_wr && !redirect && idle)
      external_data_ram_mem[link.addr[`FSQ_EXTERNAL_DATA_RAM_AW-1:0]] <= link.wdata;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      link.rdata <= 8'h00;
    else if (link.movx_rd)
      link.rdata <= external_data_ram_mem[link.addr[`FSQ_EXTERNAL_DATA_RAM_AW-1:0]];
    else if (link.movc_rd)
    begin
      if (to_scratch && !link.movc_fetch)
        link.rdata <= scratch_mem[link.addr[`FSQ_SCR_AW-1:0]];
      else
        link.rdata <= flash_mem[link.addr];
    end
    else if (link.jtag_rd)
      link.rdata <= jtag_visible ? flash_mem[link.addr] : `FSQ_UNDEF_DATA;
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign op_busy          = !idle;
  assign link.stall       = !idle;
  assign link.irq_hold    = !idle;
  assign link.ctrl_status = {sw_allow, scratch_sel, erase_en, redirect};
endmodule

// [hdl/fsq_host.sv]
/*
  Host end: stands for the core and the debug port. Software loads address, data and a
  command over a plain register port; the host issues one link request and waits out stall.
  Interrupt inputs are held pending while the device holds them, then served by priority.
  Assumes the device on the other end of the link shares sys_clk.
*/
`include "fsq_defs.svh"

module fsq_host
  import fsq_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  fsq_link_if.host        link,
  input  wire logic [3:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic [7:0]      sw_rdata,
  input  wire logic [7:0] irq_in,
  output logic [7:0]      irq_service
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  fsq_host_state_t state;
  fsq_op_t         op;
  logic [7:0]      addr_lo;
  logic [7:0]      addr_hi;
  logic [7:0]      data_reg;
  logic [7:0]      result;
  logic [7:0]      pend;

  function automatic logic [7:0] lowest_bit(input logic [7:0] v);
    lowest_bit = v & (~v + 8'h01);
  endfunction

  wire       cmd_wr  = sw_wr && (sw_addr == `FSQ_R_CMD) && (state == fsq_host_idle);
  wire       issue   = (state == fsq_host_issue);
  wire [7:0] served  = link.irq_hold ? 8'h00 : lowest_bit(pend);
  wire [7:0] status  = {link.ctrl_status, 2'b00, (pend != 8'h00), (state != fsq_host_idle)};
  wire [7:0] rd_mux  =
    (sw_addr == `FSQ_R_ADDR_LO)  ? addr_lo  :
    (sw_addr == `FSQ_R_ADDR_HI)  ? addr_hi  :
    (sw_addr == `FSQ_R_DATA)     ? data_reg :
    (sw_addr == `FSQ_R_STATUS)   ? status   :
    (sw_addr == `FSQ_R_RESULT)   ? result   :
    (sw_addr == `FSQ_R_IRQ_PEND) ? pend     : 8'h00;

  // --------------------------------------------------------------------------
  // Link strobes
  // --------------------------------------------------------------------------
  assign link.movx_wr    = issue && (op == fsq_op_movx_wr);
  assign link.movx_rd    = issue && (op == fsq_op_movx_rd);
  assign link.movc_rd    = issue && (op == fsq_op_movc_rd || op == fsq_op_fetch);
  assign link.movc_fetch = issue && (op == fsq_op_fetch);
  assign link.jtag_rd    = issue && (op == fsq_op_jtag_rd);
  assign link.jtag_wr    = issue && (op == fsq_op_jtag_wr);
  assign link.jtag_erase = issue && (op == fsq_op_jtag_era);
  assign link.sfr_wr     = issue && (op == fsq_op_sfr_wr);
  assign link.sfr_sel    = addr_lo[0];
  assign link.addr       = {addr_hi, addr_lo};
  assign link.wdata      = data_reg;

  // --------------------------------------------------------------------------
  // Sequencing and registers
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state       <= fsq_host_idle;
      op          <= fsq_op_movx_rd;
      addr_lo     <= 8'h00;
      addr_hi     <= 8'h00;
      data_reg    <= 8'h00;
      result      <= 8'h00;
      pend        <= 8'h00;
      irq_service <= 8'h00;
      sw_rdata    <= 8'h00;
    end
    else
    begin
      // A new request arriving while its bit is served stays pending.
      pend        <= (pend & ~served) | irq_in;
      irq_service <= served;
      if (sw_rd)
        sw_rdata <= rd_mux;
      if (sw_wr && state == fsq_host_idle)
      begin
        if (sw_addr == `FSQ_R_ADDR_LO)
          addr_lo <= sw_wdata;
        if (sw_addr == `FSQ_R_ADDR_HI)
          addr_hi <= sw_wdata;
        if (sw_addr == `FSQ_R_DATA)
          data_reg <= sw_wdata;
      end
      case (state)
        fsq_host_idle:
        begin
          if (cmd_wr && !link.stall)
          begin
            op    <= fsq_op_t'(sw_wdata[2:0]);
            state <= fsq_host_issue;
          end
        end
        fsq_host_issue:
          state <= fsq_host_wait;
        fsq_host_wait:
        begin
          // The core makes no progress until the device lets go.
          if (!link.stall)
          begin
            result <= link.rdata;
            state  <= fsq_host_idle;
          end
        end
        default:
          state <= fsq_host_idle;
      endcase
    end
  end
endmodule

// [verif/fsq_link_asserts.sv]
/*
  Concurrent checks on the link that joins the flash host and device ends.
  Assumes one clock and a synchronous active-high reset.
*/
module fsq_link_asserts
#(
  parameter int unsigned WRITE_CYCLES = 20,
  parameter int unsigned ERASE_CYCLES = 600
)
(
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       movx_wr,
  input wire logic       movx_rd,
  input wire logic       movc_rd,
  input wire logic       jtag_rd,
  input wire logic       jtag_wr,
  input wire logic       jtag_erase,
  input wire logic       sfr_wr,
  input wire logic       sfr_sel,
  input wire logic [7:0] wdata,
  input wire logic       stall,
  input wire logic       irq_hold,
  input wire logic [3:0] ctrl_status
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------------------
  // The kind of the last modify request picks which timing the stall must match.
  logic [23:0] run_len;
  logic        last_erase;
  wire         modify = jtag_wr | jtag_erase | movx_wr;
  wire         any_rd = movx_rd | movc_rd | jtag_rd;
  wire         erase_req = jtag_erase | (movx_wr & ctrl_status[1]);

  always_ff @(posedge sys_clk)
  begin
    run_len    <= (reset || !stall) ? 24'h0 : run_len + 24'h1;
    last_erase <= reset ? 1'b0 : (modify ? erase_req : last_erase);
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  hold_follows_stall_a: assert property (irq_hold == stall)
    else $error("interrupt hold differs from stall");
  write_time_a: assert property ($fell(stall) && !last_erase |-> run_len == 24'(WRITE_CYCLES))
    else $error("write stall length wrong");
  erase_time_a: assert property ($fell(stall) && last_erase |-> run_len == 24'(ERASE_CYCLES))
    else $error("erase stall length wrong");
  stall_cause_a: assert property ($rose(stall) |-> $past(modify))
    else $error("stall without a modify request");
  no_req_busy_a: assert property (stall |-> !(modify | any_rd | sfr_wr))
    else $error("request issued while stalled");
  read_no_stall_a: assert property (any_rd && !stall |=> !stall)
    else $error("read caused a stall");
  redirect_kept_a: assert property (ctrl_status[0] && !(sfr_wr && !sfr_sel) |=> ctrl_status[0])
    else $error("redirect bit cleared without a control write");
  ctrl_load_a: assert property (sfr_wr && !sfr_sel |=> ctrl_status[2:0] == $past(wdata[2:0]))
    else $error("control bits not loaded");
  allow_load_a: assert property (sfr_wr && sfr_sel |=> ctrl_status[3] == $past(wdata[0]))
    else $error("allow bit not loaded");

  cover property ($fell(stall) && last_erase);
  cover property ($fell(stall) && !last_erase);
  cover property (jtag_rd);
endmodule

// [verif/tb_flash_program_erase_and_lock_control.sv]
/*
  Self-checking bench: host and device joined over the link, driven through the
  software port with seeded random data and chosen corner cases.
  Assumes the short timing parameters below keep the run brief.
*/
`include "fsq_defs.svh"

module tb_flash_program_erase_and_lock_control;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int WR = 20;
  localparam int ER = 600;
  logic       sys_clk;
  logic       reset;
  logic [3:0] sw_addr;
  logic [7:0] sw_wdata;
  logic       sw_wr;
  logic       sw_rd;
  logic [7:0] sw_rdata;
  logic [7:0] irq_in;
  logic [7:0] irq_service;
  logic       op_busy;
  logic       op_refused;
  logic [7:0] ref_cnt;
  logic [7:0] pat;
  logic       irq_arm;
  logic       irq_sent;
  logic [7:0] srv_first;
  logic       srv_stall;
  int         n_mismatch;
  int         checks_done;
  integer     seed;

  fsq_link_if lnk ();
  fsq_device #(.WRITE_CYCLES(WR), .ERASE_CYCLES(ER)) fsq_device_i (.sys_clk(sys_clk),
    .reset(reset), .link(lnk.dev), .op_busy(op_busy), .op_refused(op_refused));
  fsq_host fsq_host_i (.sys_clk(sys_clk), .reset(reset), .link(lnk.host), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq_in(irq_in),
    .irq_service(irq_service));
  fsq_link_asserts #(.WRITE_CYCLES(WR), .ERASE_CYCLES(ER)) fsq_link_asserts_i (
    .sys_clk(sys_clk), .reset(reset), .movx_wr(lnk.movx_wr), .movx_rd(lnk.movx_rd),
    .movc_rd(lnk.movc_rd), .jtag_rd(lnk.jtag_rd), .jtag_wr(lnk.jtag_wr),
    .jtag_erase(lnk.jtag_erase), .sfr_wr(lnk.sfr_wr), .sfr_sel(lnk.sfr_sel),
    .wdata(lnk.wdata), .stall(lnk.stall), .irq_hold(lnk.irq_hold),
    .ctrl_status(lnk.ctrl_status));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------------------
  // One interrupt pulse is sent mid-stall; the first service pulse is recorded.
  always @(posedge sys_clk)
  begin
    if (!reset)
    begin
      irq_in   <= (lnk.stall && irq_arm && !irq_sent) ? pat : 8'h00;
      irq_sent <= irq_sent | (lnk.stall & irq_arm);
      ref_cnt  <= ref_cnt + {7'h0, op_refused};
      if (irq_service !== 8'h00 && srv_first === 8'h00)
      begin
        srv_first <= irq_service;
        srv_stall <= lnk.stall;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task automatic complete_run();
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    @(posedge sys_clk);
    d = sw_rdata;
  endtask

  task automatic op(input logic [2:0] c, input logic [15:0] a, input logic [7:0] d,
                    output logic [7:0] r);
    int n;
    logic [7:0] s;
    wr(`FSQ_R_ADDR_LO, a[7:0]);
    wr(`FSQ_R_ADDR_HI, a[15:8]);
    wr(`FSQ_R_DATA, d);
    wr(`FSQ_R_CMD, {5'h0, c});
    n = 0;
    s = 8'h01;
    while (s[0] !== 1'b0 && n < 2000)
    begin
      rd(`FSQ_R_STATUS, s);
      n++;
    end
    if (n >= 2000)
    begin
      n_mismatch++;
      $display("Error %0t: operation never finished", $time);
      complete_run();
    end
    rd(`FSQ_R_RESULT, r);
  endtask

  task automatic ctl(input logic sel, input logic [7:0] v);
    logic [7:0] r;
    op(3'h7, {15'h0, sel}, v, r);
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial
  begin
    logic [7:0] r;
    logic [7:0] d;
    logic [7:0] d2;
    logic [7:0] f0;
    seed = 91;
    n_mismatch = 0;
    checks_done = 0;
    reset = 1'b1;
    {sw_addr, sw_wdata, sw_wr, sw_rd, irq_in, ref_cnt, srv_first} = '0;
    {irq_arm, irq_sent, srv_stall} = '0;
    pat = 8'($random(seed)) | 8'h80;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    ctl(1'b0, 8'h01);
    ctl(1'b1, 8'h01);
    chk({4'h0, lnk.ctrl_status}, 8'h09);
    op(3'h0, 16'h0100, 8'h00, r);
    chk(ref_cnt, 8'h01);
    op(3'h5, 16'h0000, 8'h5a, r);
    d = 8'($random(seed)) | 8'h02;
    f0 = 8'h5a & d;
    op(3'h5, 16'h0000, d, r);
    op(3'h2, 16'h0000, 8'h00, r);
    chk(r, f0);
    ctl(1'b0, 8'h00);
    d = 8'($random(seed));
    d2 = 8'($random(seed));
    op(3'h0, 16'h0234, d, r);
    ctl(1'b0, 8'h01);
    op(3'h0, 16'h0234, d2, r);
    op(3'h1, 16'h0234, 8'h00, r);
    chk(r, d);
    op(3'h2, 16'h0234, 8'h00, r);
    chk(r, d2);
    chk({7'h0, lnk.ctrl_status[0]}, 8'h01);
    op(3'h0, 16'h01ff, d, r);
    ctl(1'b0, 8'h03);
    op(3'h0, 16'h0300, 8'h00, r);
    ctl(1'b0, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      op(3'h2, {7'h01, 9'(i * 73)}, 8'h00, r);
      chk(r, 8'hff);
    end
    op(3'h2, 16'h01ff, 8'h00, r);
    chk(r, d);
    op(3'h2, 16'h0000, 8'h00, r);
    chk(r, f0);
    ctl(1'b0, 8'h03);
    op(3'h0, 16'hfc10, 8'h00, r);
    chk(ref_cnt, 8'h02);
    d = 8'($random(seed));
    ctl(1'b0, 8'h05);
    op(3'h0, 16'h0010, d, r);
    op(3'h2, 16'h0010, 8'h00, r);
    chk(r, d);
    op(3'h3, 16'h0010, 8'h00, r);
    chk(r, 8'hff);
    ctl(1'b0, 8'h01);
    op(3'h2, 16'h0010, 8'h00, r);
    chk(r, 8'hff);
    ctl(1'b1, 8'h00);
    op(3'h0, 16'h0400, 8'h00, r);
    chk(ref_cnt, 8'h03);
    op(3'h5, 16'hfdfe, 8'hfe, r);
    op(3'h5, 16'hfdff, 8'hfe, r);
    op(3'h4, 16'h0000, 8'h00, r);
    chk(r, 8'h00);
    op(3'h4, 16'hfdff, 8'h00, r);
    chk(r, 8'hfe);
    op(3'h4, 16'h2000, 8'h00, r);
    chk(r, 8'hff);
    op(3'h5, 16'h0100, 8'h00, r);
    chk(ref_cnt, 8'h04);
    op(3'h5, 16'hfdfe, 8'h7e, r);
    op(3'h6, 16'hfdfe, 8'h00, r);
    chk(ref_cnt, 8'h05);
    op(3'h5, 16'hfdff, 8'h7c, r);
    op(3'h4, 16'hfdff, 8'h00, r);
    chk(r, 8'h7c);
    op(3'h5, 16'hfe10, 8'h00, r);
    chk(ref_cnt, 8'h06);
    ctl(1'b0, 8'h00);
    irq_arm = 1'b1;
    op(3'h5, 16'h2100, 8'h00, r);
    chk(srv_first, pat & (~pat + 8'h01));
    chk({7'h0, srv_stall}, 8'h00);
    complete_run();
  end
endmodule
